// ==== pdt_pkg.sv ====
// package for the presettable down timer channel
// assumes one 25 MHz ref_clk domain and an apb register port
package pdt_pkg;
  // -------------------------------------------------------------------
  // register byte addresses
  // -------------------------------------------------------------------
  localparam logic [11:0] ADDR_CLK = 12'h000;
  localparam logic [11:0] ADDR_MOD = 12'h004;
  localparam logic [11:0] ADDR_CTL = 12'h008;
  localparam logic [11:0] ADDR_RLD = 12'h00C;
  localparam logic [11:0] ADDR_CNT = 12'h010;
  localparam logic [11:0] ADDR_FLG = 12'h014;
  localparam logic [11:0] ADDR_IEN = 12'h018;
  // -------------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------------
  localparam int DBG_RUN_BIT = 8;
  localparam int PRESCALE_LSB = 4;
  localparam int SOURCE_LSB = 0;
  localparam int ONESHOT_BIT = 0;
  localparam int RUN_BIT = 8;
  localparam int PRESET_BIT = 1;
  localparam int ENABLE_BIT = 0;
  localparam int FLAG_BIT = 0;
  localparam int IEN_BIT = 0;
  // -------------------------------------------------------------------
  // reset values and encodings
  // -------------------------------------------------------------------
  localparam logic [15:0] RELOAD_RST = 16'hFFFF;
  localparam logic [15:0] COUNT_RST = 16'hFFFF;
  localparam logic [1:0] SRC_INTERNAL_OSC = 2'h0;
  localparam logic [1:0] SRC_LOSC = 2'h1;
  localparam logic [1:0] SRC_HOSC = 2'h2;
  localparam logic [1:0] SRC_EXT = 2'h3;
  localparam logic [3:0] PRESCALE_MAX = 4'hF;
  // clock control fields carried together
  typedef struct packed {
    logic debugRun;
    logic [3:0] prescaleSel;
    logic [1:0] sourceSel;
  } pdt_clk_s;
endpackage

// ==== pdt_down_timer.sv ====
// one channel of the presettable 16-bit down timer with apb registers
// assumes source clocks and event input arrive as async pins, synced here
`timescale 1ns/10ps
module pdt_down_timer #(
  parameter bit HAS_EVENT = 1'b1,
  parameter bit HAS_LOSC = 1'b1,
  parameter bit HAS_HOSC = 1'b1,
  parameter bit HAS_EXT = 1'b1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // clock sources, event pin and debug state
  input wire logic internalOsc,
  input wire logic lowSpeedOsc,
  input wire logic highSpeedOsc,
  input wire logic extOscClock,
  input wire logic eventInput,
  input wire logic debugMode,
  // interrupt request
  output logic underflowIrq
);
  // -------------------------------------------------------------------
  // registers and helpers
  // -------------------------------------------------------------------
  pdt_pkg::pdt_clk_s clkCfg_r;
  logic oneshotSel_r, runBit_r, presetBit_r, channelEnable_r;
  logic [15:0] reloadVal_r, countVal_r;
  logic underflowFlagBit_r, underflowIrqEn_r;
  logic [3:0] srcMeta_r, srcSync_r, srcPrev_r;
  logic [14:0] divCnt_r;
  logic wrEn, rdEn, srcTick, tick, underflow, presetDo, clkOn;

  // decode a write hitting a given address
  function automatic logic hit(input logic [11:0] a, input logic [11:0] ref_a);
    hit = (a == ref_a);
  endfunction

  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign wrEn = psel && penable && pwrite;
  assign rdEn = psel && !pwrite;

  // -------------------------------------------------------------------
  // source synchronisers, two flops each
  // -------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      srcMeta_r <= 4'h0;
      srcSync_r <= 4'h0;
      srcPrev_r <= 4'h0;
    end else begin
      srcMeta_r <= {(HAS_EVENT ? eventInput : extOscClock), highSpeedOsc, lowSpeedOsc,
                    internalOsc};
      srcSync_r <= srcMeta_r;
      srcPrev_r <= srcSync_r;
    end
  end

  // rising edge of selected source, unimplemented sources never tick
  always_comb begin
    case (clkCfg_r.sourceSel)
      pdt_pkg::SRC_INTERNAL_OSC: srcTick = srcSync_r[0] & ~srcPrev_r[0];
      pdt_pkg::SRC_LOSC: srcTick = HAS_LOSC & srcSync_r[1] & ~srcPrev_r[1];
      pdt_pkg::SRC_HOSC: srcTick = HAS_HOSC & srcSync_r[2] & ~srcPrev_r[2];
      pdt_pkg::SRC_EXT: srcTick = HAS_EXT & srcSync_r[3] & ~srcPrev_r[3];
      default: srcTick = 1'b0;
    endcase
  end

  // operating clock gate: enable and debug hold
  assign clkOn = channelEnable_r && (!debugMode || clkCfg_r.debugRun);

  // -------------------------------------------------------------------
  // power-of-two prescaler, tick when low bits all ones
  // -------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      divCnt_r <= 15'h0000;
    end else if (clkOn && srcTick) begin
      divCnt_r <= divCnt_r + 15'h0001;
    end
  end

  // tick mask: bits below the selected power must be all ones
  always_comb begin
    logic [14:0] mask;
    mask = 15'h0000;
    mask = 15'(16'h0001 << clkCfg_r.prescaleSel) - 15'h0001;
    if (clkCfg_r.prescaleSel == pdt_pkg::PRESCALE_MAX) begin
      mask = 15'h7FFF;
    end
    tick = clkOn && srcTick && ((divCnt_r & mask) == mask);
  end

  // underflow on the tick after zero: period is reload plus one ticks
  assign underflow = tick && runBit_r && (countVal_r == 16'h0000);
  assign presetDo = presetBit_r && clkOn;

  // -------------------------------------------------------------------
  // configuration registers
  // -------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      clkCfg_r <= '0;
      oneshotSel_r <= 1'b0;
      reloadVal_r <= pdt_pkg::RELOAD_RST;
      underflowIrqEn_r <= 1'b0;
      channelEnable_r <= 1'b0;
    end else if (wrEn) begin
      if (hit(paddr, pdt_pkg::ADDR_CLK)) begin
        clkCfg_r.debugRun <= pwdata[pdt_pkg::DBG_RUN_BIT];
        clkCfg_r.prescaleSel <= pwdata[pdt_pkg::PRESCALE_LSB +: 4];
        clkCfg_r.sourceSel <= pwdata[pdt_pkg::SOURCE_LSB +: 2];
      end
      if (hit(paddr, pdt_pkg::ADDR_MOD)) begin
        oneshotSel_r <= pwdata[pdt_pkg::ONESHOT_BIT];
      end
      if (hit(paddr, pdt_pkg::ADDR_RLD)) begin
        reloadVal_r <= pwdata[15:0];
      end
      if (hit(paddr, pdt_pkg::ADDR_IEN)) begin
        underflowIrqEn_r <= pwdata[pdt_pkg::IEN_BIT];
      end
      if (hit(paddr, pdt_pkg::ADDR_CTL)) begin
        channelEnable_r <= pwdata[pdt_pkg::ENABLE_BIT];
      end
    end
  end

  // -------------------------------------------------------------------
  // run bit: software start/stop, one-shot auto clear
  // -------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      runBit_r <= 1'b0;
    end else if (underflow && oneshotSel_r) begin
      runBit_r <= 1'b0;
    end else if (wrEn && hit(paddr, pdt_pkg::ADDR_CTL)) begin
      runBit_r <= pwdata[pdt_pkg::RUN_BIT];
    end
  end

  // preset request, held until the gated clock performs it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      presetBit_r <= 1'b0;
    end else if (wrEn && hit(paddr, pdt_pkg::ADDR_CTL) && pwdata[pdt_pkg::PRESET_BIT]) begin
      presetBit_r <= 1'b1;
    end else if (presetDo) begin
      presetBit_r <= 1'b0;
    end
  end

  // -------------------------------------------------------------------
  // down counter
  // -------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      countVal_r <= pdt_pkg::COUNT_RST;
    end else if (presetDo || underflow) begin
      countVal_r <= reloadVal_r;
    end else if (tick && runBit_r) begin
      countVal_r <= countVal_r - 16'h0001;
    end
  end

  // underflow flag: set wins over clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      underflowFlagBit_r <= 1'b0;
    end else if (underflow) begin
      underflowFlagBit_r <= 1'b1;
    end else if (wrEn && hit(paddr, pdt_pkg::ADDR_FLG) && pwdata[pdt_pkg::FLAG_BIT]) begin
      underflowFlagBit_r <= 1'b0;
    end
  end

  assign underflowIrq = underflowFlagBit_r && underflowIrqEn_r;

  // -------------------------------------------------------------------
  // read mux, reserved bits zero
  // -------------------------------------------------------------------
  always_comb begin
    prdata = 32'h0000_0000;
    if (rdEn) begin
      case (paddr)
        pdt_pkg::ADDR_CLK: begin
          prdata[pdt_pkg::DBG_RUN_BIT] = clkCfg_r.debugRun;
          prdata[pdt_pkg::PRESCALE_LSB +: 4] = clkCfg_r.prescaleSel;
          prdata[pdt_pkg::SOURCE_LSB +: 2] = clkCfg_r.sourceSel;
        end
        pdt_pkg::ADDR_MOD: prdata[pdt_pkg::ONESHOT_BIT] = oneshotSel_r;
        pdt_pkg::ADDR_CTL: begin
          prdata[pdt_pkg::RUN_BIT] = runBit_r;
          prdata[pdt_pkg::PRESET_BIT] = presetBit_r;
          prdata[pdt_pkg::ENABLE_BIT] = channelEnable_r;
        end
        pdt_pkg::ADDR_RLD: prdata[15:0] = reloadVal_r;
        pdt_pkg::ADDR_CNT: prdata[15:0] = countVal_r;
        pdt_pkg::ADDR_FLG: prdata[pdt_pkg::FLAG_BIT] = underflowFlagBit_r;
        pdt_pkg::ADDR_IEN: prdata[pdt_pkg::IEN_BIT] = underflowIrqEn_r;
        default: prdata = 32'h0000_0000;
      endcase
    end
  end

  // -------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------
  a_oneshot_stop: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (underflow && oneshotSel_r) |=> (!runBit_r && countVal_r == $past(reloadVal_r)))
    else $error("one-shot underflow did not stop and reload");
  a_flag_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
    underflow |=> underflowFlagBit_r)
    else $error("underflow flag not set");
  a_flag_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wrEn && paddr == pdt_pkg::ADDR_FLG && pwdata[0] && !underflow) |=> !underflowFlagBit_r)
    else $error("underflow flag not cleared by write one");
  a_irq_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (underflow && underflowIrqEn_r && !(wrEn && paddr == pdt_pkg::ADDR_IEN)) |=> underflowIrq)
    else $error("interrupt not raised on enabled underflow");
  a_debug_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (debugMode && !clkCfg_r.debugRun) |=> $stable(countVal_r))
    else $error("counter moved in debug mode");
  a_repeat_reload: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (underflow && !oneshotSel_r && !(wrEn && paddr == pdt_pkg::ADDR_CTL))
      |=> (runBit_r && countVal_r == $past(reloadVal_r)))
    else $error("repeat underflow did not reload");
  a_count_down: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (tick && runBit_r && !presetDo && countVal_r != 16'h0000)
      |=> countVal_r == $past(countVal_r) - 16'h0001)
    else $error("counter did not decrement");
  a_hold_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!runBit_r && !presetBit_r) |=> $stable(countVal_r))
    else $error("counter moved while stopped");
  a_preset_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (presetDo && !(wrEn && paddr == pdt_pkg::ADDR_CTL))
      |=> (!presetBit_r && countVal_r == $past(reloadVal_r)))
    else $error("preset did not load reload value");
  a_enable_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !channelEnable_r |-> !tick)
    else $error("tick without channel enable");

  // -------------------------------------------------------------------
  // register write and read checks
  // -------------------------------------------------------------------
  // mode bit follows a write to the mode register
  a_mode_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wrEn && paddr == pdt_pkg::ADDR_MOD) |=> oneshotSel_r == $past(pwdata[0]))
    else $error("mode bit not written");
  // counter read shows the live counter in the low half
  a_count_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (rdEn && paddr == pdt_pkg::ADDR_CNT) |-> prdata == {16'h0000, countVal_r})
    else $error("counter read wrong");
  // run bit follows software when no underflow competes
  a_run_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wrEn && paddr == pdt_pkg::ADDR_CTL && !underflow) |=> runBit_r == $past(pwdata[8]))
    else $error("run bit not written");
  // run bit holds without a write or an underflow
  a_run_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!(wrEn && paddr == pdt_pkg::ADDR_CTL) && !underflow) |=> $stable(runBit_r))
    else $error("run bit moved by itself");
  // reload register takes the written low half
  a_reload_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wrEn && paddr == pdt_pkg::ADDR_RLD) |=> reloadVal_r == $past(pwdata[15:0]))
    else $error("reload value not written");
  // interrupt enable follows its write
  a_ien_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wrEn && paddr == pdt_pkg::ADDR_IEN) |=> underflowIrqEn_r == $past(pwdata[0]))
    else $error("interrupt enable not written");
  // no request while the enable is low
  a_irq_mask: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !underflowIrqEn_r |-> !underflowIrq)
    else $error("interrupt raised while disabled");
  // flag holds without an event or a clear write
  a_flag_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!underflow && !(wrEn && paddr == pdt_pkg::ADDR_FLG)) |=> $stable(underflowFlagBit_r))
    else $error("underflow flag moved by itself");
  // underflow only from zero while running
  a_underflow_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
    underflow |-> (countVal_r == 16'h0000 && runBit_r))
    else $error("underflow from nonzero count");
  // every tick rides on an edge of the selected source
  a_tick_source: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tick |-> srcTick)
    else $error("tick without source edge");
  // prescale and source fields follow a clock register write
  a_clk_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wrEn && paddr == pdt_pkg::ADDR_CLK)
      |=> (clkCfg_r.prescaleSel == $past(pwdata[7:4]) && clkCfg_r.sourceSel == $past(pwdata[1:0])))
    else $error("clock fields not written");
  // preset stays pending while the operating clock is off
  a_preset_pend: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (presetBit_r && !clkOn) |=> presetBit_r)
    else $error("preset dropped without clock");
  // upper half of every read is zero
  a_reserved_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rdEn |-> prdata[31:16] == 16'h0000)
    else $error("reserved bits not zero");
endmodule

// ==== pdt_down_timer_test.sv ====
// self-checking bench for the presettable down timer channel
// assumes pdt_pkg compiled first; bench drives apb, sources and debug pin
`timescale 1ns/10ps
module pdt_down_timer_test;
  // clock, reset and apb
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr;
  // sources, event pin, debug state and irq
  logic internalOsc = 1'b0, lowSpeedOsc = 1'b0, highSpeedOsc = 1'b0;
  logic extOscClock = 1'b0, eventInput = 1'b0, debugMode = 1'b0;
  logic underflowIrq;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  int oc = 0;
  logic [31:0] q, q2;
  int t0, t1, rl, pre;
  logic [11:0] addrs[8] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h014, 12'h018, 12'h01C};
  logic [31:0] rstv[8] = '{32'h0, 32'h0, 32'h0, 32'hFFFF, 32'hFFFF, 32'h0, 32'h0, 32'h0};

  pdt_down_timer pdt_down_timer_i (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .internalOsc(internalOsc),
    .lowSpeedOsc(lowSpeedOsc), .highSpeedOsc(highSpeedOsc), .extOscClock(extOscClock),
    .eventInput(eventInput), .debugMode(debugMode), .underflowIrq(underflowIrq));

  // --------------------------------------------------------------
  // clocks and source waveforms
  // --------------------------------------------------------------
  always #20 ref_clk = ~ref_clk;
  // source periods 4, 6, 8 ref cycles, event 10, ext osc 14
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    oc <= oc + 1;
    internalOsc <= (oc % 4) < 2;
    lowSpeedOsc <= (oc % 6) < 3;
    highSpeedOsc <= (oc % 8) < 4;
    eventInput <= (oc % 10) < 5;
    extOscClock <= (oc % 14) < 7;
  end

  // --------------------------------------------------------------
  // bench tasks
  // --------------------------------------------------------------
  // expected source period in ref cycles per source code
  function automatic int src_period(input int s);
    return (s + 2) * 2;
  endfunction
  task automatic close_out();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
      n_mismatch++;
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    chk(32'(pslverr), 32'h0, "slave error");
    if (n >= 50) chk(1'b0, 1'b1, "apb hang");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  // waits for the irq level, returns the cycle stamp
  task automatic wait_irq(output int t);
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (underflowIrq !== 1'b1 && n < 5000);
    if (n >= 5000) chk(1'b0, 1'b1, "irq wait");
    t = cyc;
  endtask

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    void'($urandom(32'h5DE7));
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    // reset values and unmapped place
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, addrs[i], 32'h0, q);
      chk(q, rstv[i], "reset value");
    end
    // reserved bits and read-only counter
    wr(12'h000, 32'hFFFF_FFFF);
    apb(1'b0, 12'h000, 32'h0, q);
    chk(q, 32'h0000_01F3, "clock select fields");
    wr(12'h010, 32'h0000_1234);
    apb(1'b0, 12'h010, 32'h0, q);
    chk(q, 32'h0000_FFFF, "count read only");
    wr(12'h01C, 32'hFFFF_FFFF);
    apb(1'b0, 12'h01C, 32'h0, q);
    chk(q, 32'h0, "unmapped");
    // repeat-mode period for every source
    for (int s = 0; s < 4; s++) begin
      rl = 2 + $urandom_range(0, 3);
      pre = $urandom_range(0, 2);
      wr(12'h004, 32'h0);
      wr(12'h000, 32'(pre << 4) | 32'(s));
      wr(12'h00C, 32'(rl));
      wr(12'h014, 32'h1);
      wr(12'h018, 32'h1);
      wr(12'h008, 32'h0000_0103);
      wait_irq(t0);
      wr(12'h014, 32'h1);
      wait_irq(t1);
      chk(32'(t1 - t0), 32'((rl + 1) * (1 << pre) * src_period(s)), "period");
      wr(12'h008, 32'h0000_0001);
      apb(1'b0, 12'h008, 32'h0, q);
      chk(q, 32'h0000_0001, "run bit stop");
      apb(1'b0, 12'h010, 32'h0, q);
      repeat (30) @(posedge ref_clk);
      apb(1'b0, 12'h010, 32'h0, q2);
      chk(q2, q, "stopped holds");
    end
    // debug gating while running
    wr(12'h00C, 32'h0000_FFFF);
    wr(12'h000, 32'h0);
    wr(12'h008, 32'h0000_0103);
    debugMode <= 1'b1;
    repeat (8) @(posedge ref_clk);
    apb(1'b0, 12'h010, 32'h0, q);
    repeat (40) @(posedge ref_clk);
    apb(1'b0, 12'h010, 32'h0, q2);
    chk(q2, q, "debug gated");
    apb(1'b0, 12'h008, 32'h0, q);
    chk(q, 32'h0000_0103, "preset pending");
    wr(12'h000, 32'h0000_0100);
    repeat (40) @(posedge ref_clk);
    apb(1'b0, 12'h010, 32'h0, q2);
    chk(32'(q2 !== q), 32'h1, "debug run");
    debugMode <= 1'b0;
    wr(12'h008, 32'h0000_0100);
    repeat (8) @(posedge ref_clk);
    apb(1'b0, 12'h010, 32'h0, q);
    repeat (40) @(posedge ref_clk);
    apb(1'b0, 12'h010, 32'h0, q2);
    chk(q2, q, "enable off holds");
    // preset while stopped
    wr(12'h008, 32'h0000_0001);
    rl = 1 + $urandom_range(0, 5);
    wr(12'h00C, 32'(rl));
    wr(12'h008, 32'h0000_0003);
    apb(1'b0, 12'h008, 32'h0, q);
    chk(q, 32'h0000_0001, "preset self clear");
    apb(1'b0, 12'h010, 32'h0, q);
    chk(q, 32'(rl), "preset load");
    // one-shot underflow, then flag and enable
    wr(12'h004, 32'h1);
    wr(12'h014, 32'h1);
    wr(12'h018, 32'h1);
    wr(12'h008, 32'h0000_0103);
    wait_irq(t0);
    apb(1'b0, 12'h008, 32'h0, q);
    chk(q, 32'h0000_0001, "one-shot stop");
    apb(1'b0, 12'h010, 32'h0, q);
    chk(q, 32'(rl), "one-shot reload");
    wr(12'h018, 32'h0);
    apb(1'b0, 12'h014, 32'h0, q);
    chk(q, 32'h1, "flag set");
    chk(32'(underflowIrq), 32'h0, "irq masked");
    wr(12'h014, 32'h0);
    apb(1'b0, 12'h014, 32'h0, q);
    chk(q, 32'h1, "flag write zero");
    wr(12'h018, 32'h1);
    #1;
    chk(32'(underflowIrq), 32'h1, "irq enabled");
    wr(12'h014, 32'h1);
    #1;
    chk(32'(underflowIrq), 32'h0, "irq cleared");
    close_out();
  end

  // watchdog
  initial begin
    #(40 * 60000);
    n_mismatch++;
    close_out();
  end
endmodule
